// *** core/dhc_top.sv ***
/*
  Device end of the host command handshake: pin synchronisers, handshake
  controller, command byte capture into buffer RAM, command decode and
  the four completion status bytes.
  Assumes host pins are asynchronous to mclk_i and that the seek and
  read/write logic reports its events as one-cycle pulses on mclk_i.
*/
`timescale 1ns/1ns
`include "dhc_map.svh"
module dhc_top
  import dhc_pkg::*;
#(
  parameter logic [23:0] MAX_BLOCK  = 24'h00ffff,
  parameter int          FIFO_DEPTH = 8
) (
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  input  wire logic        cmd_n_i,
  input  wire logic        bus_direction_line_i,
  input  wire logic        pstrb_n_i,
  input  wire logic [7:0]  incoming_data_bus_i,
  output logic      [7:0]  host_data_o,
  output logic             host_data_oe_o,
  output logic             device_handshake_flag_o,
  output logic             input_mux_select_hi_o,
  output logic             input_mux_select_lo_o,
  output logic             input_mux_gate_o,
  output logic             buffer_ram_select_o,
  output logic             buffer_ram_write_o,
  output logic             counter_preset_pulse_o,
  output logic      [10:0] buffer_addr_o,
  output logic      [7:0]  internal_data_bus_o,
  output logic             cmd_fifo_ready_o,
  output logic             op_start_o,
  output logic      [1:0]  op_code_o,
  output logic      [23:0] block_number_o,
  output logic      [7:0]  retry_count_o,
  output logic      [7:0]  spare_threshold_o,
  input  wire logic        op_done_i,
  input  wire logic        op_fail_i,
  input  wire logic        write_overrun_i,
  input  wire logic        spares_unreadable_i,
  input  wire logic        spares_updated_i,
  input  wire logic        header_try_fail_i,
  input  wire logic        crc_err_i,
  input  wire logic        data_phase_i,
  input  wire logic        post_seek_i,
  input  wire logic        search_i,
  input  wire logic        rev_pulse_i,
  input  wire logic        sparing_i,
  input  wire logic [7:0]  spared_count_i,
  input  wire logic        badblock_ovf_i,
  input  wire logic        status_sector_bad_i,
  input  wire logic        wrong_track_i,
  input  wire logic        reread_err_i,
  output logic      [7:0]  status_one_o,
  output logic      [7:0]  status_two_o,
  output logic      [7:0]  status_three_o,
  output logic      [7:0]  status_four_o
);
  dhc_regs_t  q;
  dhc_regs_t  d;
  logic [7:0] ram_rdata;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] set3;
  logic       clr;
  logic       strobe;
  logic       cmd_lo;
  logic       dir_hi;
  logic [7:0] hdata;

  dhc_stream_if #(.W(8)) wr_s ();
  dhc_stream_if #(.W(8)) rd_s ();

  // a bit moves only once the second and third stages agree
  function automatic logic [10:0] settle(input logic [10:0] s2,
                                         input logic [10:0] s3,
                                         input logic [10:0] old);
    logic [10:0] same;
    same   = ~(s2 ^ s3);
    settle = (s2 & same) | (old & ~same);
  endfunction : settle

  // hardware set wins over a clear in the same cycle
  function automatic logic [7:0] sticky(input logic [7:0] old,
                                        input logic [7:0] set,
                                        input logic       clr_en);
    sticky = (old & ~{8{clr_en}}) | set;
  endfunction : sticky

  assign cmd_lo = ~q.stb[`DHC_SYNC_CMD];
  assign dir_hi = q.stb[`DHC_SYNC_DIR];
  assign hdata  = q.stb[7:0];

  assign wr_s.valid = strobe && (q.state == st_recv);
  assign wr_s.data  = hdata;
  assign rd_s.ready = (q.state == st_recv) && !q.ram_we;

  dhc_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk_i  (mclk_i),
    .nrst_i (nrst_i),
    .wr     (wr_s),
    .rd     (rd_s)
  );

  dhc_ram #(.AW(11)) u_ram (
    .clk_i   (mclk_i),
    .sel_i   (q.ram_sel),
    .we_i    (q.ram_we),
    .addr_i  (q.addr),
    .wdata_i (q.wdata),
    .rdata_o (ram_rdata)
  );

  always_comb
  begin
    d = q;
    d.sy1 = {cmd_n_i, bus_direction_line_i, pstrb_n_i, incoming_data_bus_i};
    d.sy2 = q.sy1;
    d.sy3 = q.sy2;
    d.stb = settle(q.sy2, q.sy3, q.stb);
    // strobe end is the rising edge of the low pulse
    strobe = d.stb[`DHC_SYNC_STB] && !q.stb[`DHC_SYNC_STB];
    d.load = 1'b0;
    d.op_start = 1'b0;
    d.fifo_rdy = wr_s.ready;
    clr = 1'b0;
    set1 = '0;
    set3 = '0;
    case (q.state)
      st_idle:
      begin
        d.flag = 1'b1;
        if (cmd_lo)
        begin
          d.flag  = 1'b0;
          d.state = st_hs_low;
        end
      end
      st_hs_low:
        if (!cmd_lo)
        begin
          d.dout  = `DHC_RESP_HELLO;
          d.zr    = `DHC_RESP_HELLO;
          d.flag  = 1'b1;
          d.state = st_hello;
        end
      st_hello:
        if (cmd_lo && !dir_hi)
        begin
          d.msel_hi = 1'b0;
          d.msel_lo = 1'b0;
          d.gate    = 1'b1;
          d.flag    = 1'b0;
          d.state   = st_chk55;
          clr       = 1'b1;
        end
      st_chk55:
      begin
        d.zr = hdata;
        if (hdata == `DHC_ACK_BYTE)
        begin
          d.load    = 1'b1;
          d.addr    = `DHC_CMD_BASE;
          d.ram_sel = 1'b1;
          d.state   = st_recv;
        end
        else
        begin
          d.msel_hi = 1'b1;
          d.msel_lo = 1'b1;
          d.gate    = 1'b0;
          d.flag    = 1'b1;
          d.state   = st_idle;
        end
      end
      st_recv:
      begin
        // a strobe into a full FIFO is lost and reported as an overrun
        if (strobe && !wr_s.ready)
          set1[`DHC_S1_WABORT] = 1'b1;
        if (q.ram_we)
        begin
          d.ram_we = 1'b0;
          d.addr   = q.addr + 11'h001;
        end
        else if (rd_s.valid)
        begin
          d.ram_we = 1'b1;
          d.wdata  = rd_s.data;
          d.zr     = rd_s.data;
        end
        else if (!cmd_lo && dir_hi)
        begin
          d.gate    = 1'b0;
          d.msel_hi = 1'b1;
          d.msel_lo = 1'b1;
          d.addr    = `DHC_CMD_BASE;
          d.idx     = '0;
          d.state   = st_read;
        end
      end
      st_read:
      begin
        d.zr = ram_rdata;
        case (q.idx)
          3'h0:    d.cmd_id     = ram_rdata;
          3'h1:    d.lba[23:16] = ram_rdata;
          3'h2:    d.lba[15:8]  = ram_rdata;
          3'h3:    d.lba[7:0]   = ram_rdata;
          3'h4:    d.retry      = ram_rdata;
          default: d.spare      = ram_rdata;
        endcase
        d.addr = q.addr + 11'h001;
        d.idx  = q.idx + 3'h1;
        if (q.idx == `DHC_CMD_LAST_IDX)
        begin
          d.ram_sel = 1'b0;
          d.state   = st_decode;
        end
      end
      st_decode:
      begin
        set3[`DHC_S3_BAD_BLOCK] = (q.lba > MAX_BLOCK);
        d.flag  = 1'b1;
        d.state = st_resp;
        case (q.cmd_id)
          `DHC_ID_READ:    d.dout = `DHC_RESP_READ;
          `DHC_ID_WRITE:   d.dout = `DHC_RESP_WRITE;
          `DHC_ID_WVERIFY: d.dout = `DHC_RESP_WVERIFY;
          default:
          begin
            // unknown command: report failure and go back to idle
            set1[`DHC_S1_FAIL] = 1'b1;
            d.state = st_idle;
          end
        endcase
        d.zr = d.dout;
      end
      st_resp:
      begin
        if (!dir_hi)
        begin
          d.msel_hi = 1'b0;
          d.msel_lo = 1'b0;
          d.gate    = 1'b1;
        end
        if (cmd_lo && !dir_hi)
        begin
          d.zr      = hdata;
          d.msel_hi = 1'b1;
          d.msel_lo = 1'b1;
          d.gate    = 1'b0;
          if (hdata == `DHC_ACK_BYTE)
          begin
            set1[`DHC_S1_ACKED] = 1'b1;
            d.state = st_go;
          end
          else
            d.state = st_idle;
        end
      end
      st_go:
        if (!cmd_lo)
        begin
          d.op_start = 1'b1;
          d.state    = st_busy;
        end
      st_busy:
        // seek plus the data handshake run in the read/write logic
        if (op_done_i)
        begin
          d.flag  = 1'b1;
          d.state = st_idle;
        end
      default:
        d.state = st_idle;
    endcase

    if (clr || !search_i || post_seek_i)
      d.revs = '0;
    else if (rev_pulse_i)
      d.revs = q.revs + 4'h1;
    if (clr)
      d.tries = '0;
    else if (header_try_fail_i && q.tries != 2'h3)
      d.tries = q.tries + 2'h1;

    set1[`DHC_S1_WABORT]  = set1[`DHC_S1_WABORT] | write_overrun_i
                            | spares_unreadable_i;
    set1[`DHC_S1_LOST]    = spares_updated_i;
    set1[`DHC_S1_SEEK]    = header_try_fail_i
                            && (d.tries == `DHC_SEEK_TRIES);
    set1[`DHC_S1_CRC]     = crc_err_i && data_phase_i
                            && !post_seek_i;
    set1[`DHC_S1_TIMEOUT] = (d.revs == `DHC_TIMEOUT_REVS)
                            && rev_pulse_i;
    set1[`DHC_S1_FAIL]    = set1[`DHC_S1_FAIL] | op_fail_i
                            | (|set1[6:2]);
    set2 = '0;
    set2[`DHC_S2_ONETRY]    = header_try_fail_i;
    set2[`DHC_S2_SPARED]    = sparing_i;
    set2[`DHC_S2_WRONG_TRK] = wrong_track_i;
    set2[`DHC_S2_SPARE_OVF] = spared_count_i > `DHC_SPARE_LIMIT;
    set2[`DHC_S2_BAD_OVF]   = badblock_ovf_i;
    set2[`DHC_S2_STAT_SECT] = status_sector_bad_i;
    d.s1 = sticky(q.s1, set1, clr);
    d.s2 = sticky(q.s2, set2, clr);
    d.s3 = sticky(q.s3, set3, clr);
    // the reset mark ignores the command clear and stays until the first
    // operation completes
    d.s3[`DHC_S3_RESET_BIT] = q.s3[`DHC_S3_RESET_BIT];
    if (q.state == st_busy && op_done_i)
      d.s3[`DHC_S3_RESET_BIT] = 1'b0;
    if (clr)
      d.s4 = '0;
    else if (reread_err_i && q.s4 != 8'hff)
      d.s4 = q.s4 + 8'h01;
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      q         <= '0;
      q.sy1     <= `DHC_SYNC_IDLE;
      q.sy2     <= `DHC_SYNC_IDLE;
      q.sy3     <= `DHC_SYNC_IDLE;
      q.stb     <= `DHC_SYNC_IDLE;
      q.state   <= st_idle;
      q.flag    <= 1'b1;
      q.msel_hi <= 1'b1;
      q.msel_lo <= 1'b1;
      q.s3      <= `DHC_S3_RESET;
    end
    else
      q <= d;
  end

  assign host_data_o             = q.dout;
  assign host_data_oe_o          = q.stb[`DHC_SYNC_DIR];
  assign device_handshake_flag_o = q.flag;
  assign input_mux_select_hi_o   = q.msel_hi;
  assign input_mux_select_lo_o   = q.msel_lo;
  assign input_mux_gate_o        = q.gate;
  assign buffer_ram_select_o     = q.ram_sel;
  assign buffer_ram_write_o      = q.ram_we;
  assign counter_preset_pulse_o  = q.load;
  assign buffer_addr_o           = q.addr;
  assign internal_data_bus_o     = q.zr;
  assign cmd_fifo_ready_o        = q.fifo_rdy;
  assign op_start_o              = q.op_start;
  assign op_code_o               = q.cmd_id[1:0];
  assign block_number_o          = q.lba;
  assign retry_count_o           = q.retry;
  assign spare_threshold_o       = q.spare;
  assign status_one_o            = q.s1;
  assign status_two_o            = q.s2;
  assign status_three_o          = q.s3;
  assign status_four_o           = q.s4;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  idle_flag_high_a: assert property (
    q.state == st_idle |-> q.flag && q.msel_hi && !q.gate)
    else $error("flag not high while idle");
  flag_drop_a: assert property (
    q.state == st_idle && cmd_lo |=> !q.flag)
    else $error("flag did not drop on command low");
  hello_byte_a: assert property (
    $rose(q.flag) && q.state == st_hello |-> q.dout == 8'h01)
    else $error("hello byte not 01 when flag rose");
  mux_route_a: assert property (
    q.state == st_chk55 |-> !q.msel_hi && !q.msel_lo && q.gate)
    else $error("mux not routed to incoming data");
  preset_addr_a: assert property (
    q.load |-> q.addr == 11'h010 && !q.addr[10] && q.ram_sel)
    else $error("preset address wrong");
  write_incr_a: assert property (
    q.ram_we |=> !q.ram_we && q.addr == $past(q.addr) + 11'h001)
    else $error("address not incremented after write");
  resp_code_a: assert property (
    q.state == st_resp |-> q.flag || !dir_hi ##0
    (q.dout inside {8'h02, 8'h03, 8'h04}))
    else $error("response code out of range");
  nak_abort_a: assert property (
    q.state == st_resp && cmd_lo && !dir_hi && hdata != 8'h55
    |=> q.state == st_idle && !q.s1[7])
    else $error("bad answer did not abort");
  crc_gate_a: assert property (
    !q.s1[3] && (post_seek_i || !data_phase_i) |=> !q.s1[3])
    else $error("crc bit set outside data phase");
  seek_fail_a: assert property (
    $rose(q.s1[4]) |-> q.s1[0] && q.s2[7])
    else $error("seek error without fail and try bits");
  reread_count_a: assert property (
    reread_err_i && !clr && q.s4 != 8'hff |=> q.s4 == $past(q.s4) + 8'h01)
    else $error("reread count did not step");

  hello_seen_c: cover property (q.state == st_hs_low ##[1:20] st_hello
    == q.state);
  recv_write_c: cover property (q.ram_we ##1 q.state == st_recv);
  op_start_c: cover property (q.op_start);
  abort_c: cover property (q.state == st_chk55 ##1 q.state == st_idle);
endmodule : dhc_top

// *** core/dhc_map.svh ***
/*
  Constants of the host command handshake: byte codes, buffer addresses,
  status bit positions, reset values and limits.
  Assumes it is included by bare name, after which only `defines exist.
*/
`ifndef DHC_MAP_SVH
`define DHC_MAP_SVH

`define DHC_ACK_BYTE      8'h55
`define DHC_RESP_HELLO    8'h01
`define DHC_RESP_READ     8'h02
`define DHC_RESP_WRITE    8'h03
`define DHC_RESP_WVERIFY  8'h04
`define DHC_ID_READ       8'h00
`define DHC_ID_WRITE      8'h01
`define DHC_ID_WVERIFY    8'h02

`define DHC_CMD_BASE      11'h010
`define DHC_CMD_LAST_IDX  3'h5
`define DHC_RAM_SEL_BIT   10

`define DHC_SYNC_IDLE     11'h700
`define DHC_SYNC_CMD      10
`define DHC_SYNC_DIR      9
`define DHC_SYNC_STB      8

`define DHC_S1_ACKED      7
`define DHC_S1_WABORT     6
`define DHC_S1_LOST       5
`define DHC_S1_SEEK       4
`define DHC_S1_CRC        3
`define DHC_S1_TIMEOUT    2
`define DHC_S1_FAIL       0
`define DHC_S2_ONETRY     7
`define DHC_S2_SPARE_OVF  6
`define DHC_S2_BAD_OVF    4
`define DHC_S2_STAT_SECT  3
`define DHC_S2_SPARED     2
`define DHC_S2_WRONG_TRK  1
`define DHC_S3_RESET_BIT  7
`define DHC_S3_BAD_BLOCK  6
`define DHC_S3_RESET      8'h80

`define DHC_SPARE_LIMIT   8'h20
`define DHC_SEEK_TRIES    2'h3
`define DHC_TIMEOUT_REVS  4'h9

`endif

// *** core/dhc_pkg.sv ***
/*
  Types of the host command handshake block: controller states and the
  register image of the top module.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dhc_pkg;

  typedef enum logic [3:0] {
    st_idle   = 4'h0,
    st_hs_low = 4'h1,
    st_hello  = 4'h2,
    st_chk55  = 4'h3,
    st_recv   = 4'h4,
    st_read   = 4'h5,
    st_decode = 4'h6,
    st_resp   = 4'h7,
    st_go     = 4'h8,
    st_busy   = 4'h9
  } dhc_state_t;

  typedef struct packed {
    logic [10:0] sy1;
    logic [10:0] sy2;
    logic [10:0] sy3;
    logic [10:0] stb;
    dhc_state_t  state;
    logic        flag;
    logic        msel_hi;
    logic        msel_lo;
    logic        gate;
    logic        ram_sel;
    logic        ram_we;
    logic        load;
    logic        op_start;
    logic        fifo_rdy;
    logic [7:0]  dout;
    logic [7:0]  zr;
    logic [7:0]  wdata;
    logic [10:0] addr;
    logic [2:0]  idx;
    logic [7:0]  cmd_id;
    logic [23:0] lba;
    logic [7:0]  retry;
    logic [7:0]  spare;
    logic [1:0]  tries;
    logic [3:0]  revs;
    logic [7:0]  s1;
    logic [7:0]  s2;
    logic [7:0]  s3;
    logic [7:0]  s4;
  } dhc_regs_t;

endpackage : dhc_pkg

// *** core/dhc_stream_if.sv ***
/*
  Valid/ready byte stream between the handshake core and its FIFO.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ns
interface dhc_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dhc_stream_if

// *** core/dhc_fifo.sv ***
/*
  Command byte FIFO between the strobe capture and the buffer RAM.
  Assumes D is a power of two and one clock for both sides.
*/
`timescale 1ns/1ns
module dhc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic     clk_i,
  input  wire logic     nrst_i,
  dhc_stream_if.snk     wr,
  dhc_stream_if.src     rd
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } dhc_fifo_st_t;

  dhc_fifo_st_t q;
  dhc_fifo_st_t d;
  logic [W-1:0] mem [D];
  logic         push;
  logic         pop;

  assign wr.ready = (q.cnt != (AW+1)'(D));
  assign rd.valid = (q.cnt != '0);
  assign rd.data  = mem[q.rp];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_comb
  begin
    d = q;
    if (push)
      d.wp = q.wp + AW'(1);
    if (pop)
      d.rp = q.rp + AW'(1);
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      q <= '0;
    else
      q <= d;
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[q.wp] <= wr.data;
  end
endmodule : dhc_fifo

// *** core/dhc_ram.sv ***
/*
  Buffer RAM of the controller; address bit ten must be low to select it.
  Assumes write strobe, address and data come straight from flip-flops.
*/
`timescale 1ns/1ns
module dhc_ram #(
  parameter int AW = 11
) (
  input  wire logic          clk_i,
  input  wire logic          sel_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [7:0]    wdata_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem [2**(AW-1)];

  // asynchronous read keeps the command scan at one byte per clock
  assign rdata_o = mem[addr_i[AW-2:0]];

  always_ff @(posedge clk_i)
  begin
    if (sel_i && we_i && !addr_i[AW-1])
      mem[addr_i[AW-2:0]] <= wdata_i;
  end
endmodule : dhc_ram

// *** bench/dhc_host_model.sv ***
/*
  Host side of the command handshake: command pin, direction, strobe and
  data. Assumes its tasks are entered just after a rising clock edge.
*/
`timescale 1ns/1ns
module dhc_host_model (
  input  wire logic       clk_i,
  input  wire logic       flag_i,
  input  wire logic       gate_i,
  input  wire logic [7:0] rdata_i,
  output logic            cmd_n_o,
  output logic            dir_o,
  output logic            strb_n_o,
  output logic      [7:0] data_o
);
  int misses = 0;

  initial
  begin
    cmd_n_o  = 1'b1;
    dir_o    = 1'b1;
    strb_n_o = 1'b1;
    data_o   = 8'h00;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  // bounded wait so a dead device cannot hang the run
  task automatic await(input logic on_gate, input logic v);
    int k;
    k = 0;
    while (((on_gate ? gate_i : flag_i) !== v) && k < 300)
    begin
      step(1);
      k++;
    end
    if (k == 300)
      misses++;
  endtask : await

  task automatic run(input logic [47:0] msg, input logic [7:0] ack,
                     output logic [7:0] hello, output logic [7:0] resp);
    cmd_n_o = 1'b0;
    await(1'b0, 1'b0);
    step(2);
    cmd_n_o = 1'b1;
    await(1'b0, 1'b1);
    hello   = rdata_i;
    dir_o   = 1'b0;
    data_o  = 8'h55;
    step(2);
    cmd_n_o = 1'b0;
    await(1'b1, 1'b1);
    for (int i = 5; i >= 0; i--)
    begin
      data_o   = msg[i*8 +: 8];
      step(3);
      strb_n_o = 1'b0;
      step(5);
      strb_n_o = 1'b1;
      step(6);
    end
    dir_o   = 1'b1;
    data_o  = ~data_o;
    step(2);
    cmd_n_o = 1'b1;
    await(1'b0, 1'b1);
    resp    = rdata_i;
    step(2);
    dir_o   = 1'b0;
    data_o  = ack;
    step(2);
    cmd_n_o = 1'b0;
    step(8);
    cmd_n_o = 1'b1;
    step(2);
    dir_o   = 1'b1;
    data_o  = ~data_o;
  endtask : run
endmodule : dhc_host_model

// *** bench/test_disk_host_command_handshake.sv ***
/*
  Self-checking bench of the host command handshake block.
  Assumes the core files and the host model are compiled first.
*/
`timescale 1ns/1ns
`include "dhc_map.svh"
module test_disk_host_command_handshake;
  logic mclk_i, nrst_i, cmd_n_i, bus_direction_line_i, pstrb_n_i;
  logic [7:0] incoming_data_bus_i, host_data_o, internal_data_bus_o, hdrv;
  logic host_data_oe_o, device_handshake_flag_o, input_mux_select_hi_o;
  logic input_mux_select_lo_o, input_mux_gate_o, buffer_ram_select_o;
  logic buffer_ram_write_o, counter_preset_pulse_o, cmd_fifo_ready_o;
  logic op_start_o, data_phase_i, post_seek_i, search_i;
  logic [10:0] buffer_addr_o;
  logic [1:0]  op_code_o;
  logic [23:0] block_number_o;
  logic [7:0]  retry_count_o, spare_threshold_o, spared_count_i;
  logic [7:0]  status_one_o, status_two_o, status_three_o, status_four_o;
  logic [12:0] ev;
  logic [19:0] wq[$];
  wire logic op_done_i, spares_unreadable_i, rev_pulse_i, reread_err_i;
  wire logic wrong_track_i, status_sector_bad_i, badblock_ovf_i, sparing_i;
  wire logic header_try_fail_i, crc_err_i, spares_updated_i;
  wire logic write_overrun_i, op_fail_i;
  int errors = 0, num_checks = 0, starts = 0, writes = 0, loads = 0;
  int pos[10] = '{0, 6, 5, 3, 15, 10, 12, 11, 9, 24};

  assign {op_done_i, spares_unreadable_i, rev_pulse_i, reread_err_i,
          wrong_track_i, status_sector_bad_i, badblock_ovf_i, sparing_i,
          header_try_fail_i, crc_err_i, spares_updated_i, write_overrun_i,
          op_fail_i} = ev;
  // the host drives while its direction pin is low; with neither side on,
  // the host model's inverted byte stands for the floating lines
  assign incoming_data_bus_i = (bus_direction_line_i && host_data_oe_o)
                               ? host_data_o : hdrv;

  dhc_top #(.MAX_BLOCK(24'h00ffff), .FIFO_DEPTH(8)) u_dut (.*);
  dhc_host_model u_host (.clk_i(mclk_i), .flag_i(device_handshake_flag_o),
    .gate_i(input_mux_gate_o), .rdata_i(host_data_o), .cmd_n_o(cmd_n_i),
    .dir_o(bus_direction_line_i), .strb_n_o(pstrb_n_i), .data_o(hdrv));

  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
  begin
    if (op_start_o === 1'b1)
      starts++;
    if (buffer_ram_write_o === 1'b1)
      writes++;
    if (counter_preset_pulse_o === 1'b1)
      loads++;
    // what the RAM is handed on each write strobe
    if (buffer_ram_write_o === 1'b1)
      wq.push_back({buffer_ram_select_o, buffer_addr_o, internal_data_bus_o});
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic pulse(input int b, input int n);
    repeat (n)
    begin
      ev[b] = 1'b1;
      u_host.step(1);
      ev[b] = 1'b0;
      u_host.step(1);
    end
  endtask : pulse

  task automatic report_and_stop();
    errors += u_host.misses;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #200000;
    errors++;
    report_and_stop();
  end

  initial
  begin
    logic [23:0] lba;
    logic [15:0] rs;
    logic [7:0]  hello, resp;
    logic [31:0] st;
    logic [47:0] m;
    int          cid;
    int          exp_q[$];
    ev = '0;
    nrst_i = 1'b0;
    data_phase_i = 1'b1;
    post_seek_i = 1'b0;
    search_i = 1'b1;
    spared_count_i = 8'h00;
    void'($urandom(32'hcba78ae1));
    repeat (4) @(posedge mclk_i);
    #1 nrst_i = 1'b1;
    chk({device_handshake_flag_o, host_data_oe_o, status_three_o},
        {2'b11, `DHC_S3_RESET});
    for (int id = 0; id < 4; id++)
    begin
      cid = (id == 3) ? 0 : id;
      lba = {(id == 2) ? 8'h01 : 8'h00, 16'($urandom)};
      rs  = 16'($urandom);
      m   = {8'(cid), lba, rs};
      exp_q.push_back(cid + 2);
      u_host.run(m, (id == 3) ? 8'haa : `DHC_ACK_BYTE, hello, resp);
      // op_start follows the host's last command rise by five clocks
      u_host.step(6);
      chk(hello, `DHC_RESP_HELLO);
      chk(resp, exp_q.pop_front());
      chk(writes, 6 * (id + 1));
      chk(loads, id + 1);
      for (int k = 0; k < 6; k++)
        chk(wq.pop_front(), {1'b1, `DHC_CMD_BASE + 11'(k),
                             m[(5 - k) * 8 +: 8]});
      chk(starts, (id < 3) ? id + 1 : 3);
      chk(status_one_o, (id < 3) ? 8'h80 : 8'h00);
      chk(status_three_o, {id == 0, id == 2, 6'h00});
      if (id < 3)
      begin
        chk({op_code_o, block_number_o}, {cid[1:0], lba});
        chk({retry_count_o, spare_threshold_o}, rs);
      end
      if (id == 1)
      begin
        post_seek_i = 1'b1;
        pulse(3, 1);
        chk(status_one_o[3], 1'b0);
        post_seek_i = 1'b0;
        for (int e = 0; e < 10; e++)
        begin
          pulse(e, 1);
          st = {status_four_o, status_three_o, status_two_o, status_one_o};
          chk(st[pos[e]], 1'b1);
        end
        pulse(4, 2);
        pulse(10, 9);
        chk({status_one_o[4], status_one_o[2]}, 2'b11);
        spared_count_i = `DHC_SPARE_LIMIT;
        u_host.step(2);
        chk(status_two_o[6], 1'b0);
        spared_count_i = `DHC_SPARE_LIMIT + 8'h01;
        u_host.step(2);
        chk(status_two_o[6], 1'b1);
        spared_count_i = 8'h00;
      end
      if (id < 3)
        pulse(12, 1);
      u_host.step(4);
      chk({device_handshake_flag_o, cmd_fifo_ready_o, host_data_oe_o,
           input_mux_select_hi_o, input_mux_select_lo_o, input_mux_gate_o},
          6'b111110);
    end
    report_and_stop();
  end
endmodule : test_disk_host_command_handshake
